// >>> lhi_pkg.sv
package lhi_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int unsigned LHI_DW = 8; // host data bus width
	localparam int unsigned LHI_SER_BITS = 8; // bits per serial byte
	localparam logic [2:0] LHI_SER_LAST = 3'h7; // index of last serial bit
	localparam int unsigned LHI_BUSY_BIT = 7; // busy indicator position in status byte
	localparam int unsigned LHI_SER_IN_BIT = 7; // serial data pin
	localparam int unsigned LHI_SER_CLK_BIT = 6; // serial clock pin

	// ------------------------------------------------------------
	// strap and select encodings
	// ------------------------------------------------------------
	localparam logic LHI_TYPE_68 = 1'b1; // host type strap high: 68 style
	localparam logic LHI_MODE_PAR = 1'b1; // interface strap high: parallel
	localparam logic LHI_DCS_DATA = 1'b1; // command/data select high: display data

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned LHI_MCLK_HZ = 10000000; // system clock rate
	localparam int unsigned LHI_EXT_WIN_NS = 1600; // external clock activity window
	localparam int unsigned LHI_EXT_WIN_CYC = (LHI_EXT_WIN_NS * (LHI_MCLK_HZ / 1000000)) / 1000;

	// ------------------------------------------------------------
	// parallel transfer states (gray along idle-write-push)
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LHI_ST_IDLE = 2'h0,
		LHI_ST_WR = 2'h1,
		LHI_ST_PUSH = 2'h3,
		LHI_ST_RD = 2'h2
	} lhi_state_t;

endpackage

// >>> lhi_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// two-flop synchroniser, one per bit
// ------------------------------------------------------------
module lhi_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset of the receiving domain
	input wire logic clk_i,
	input wire logic rst_i,
	// asynchronous level in, synchronised level out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_r; // first stage, read only by second stage
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r; // second stage
	logic [W-1:0] q_nxt;

	// next values
	always_comb begin
		meta_nxt = d_i;
		q_nxt = meta_r;
		if (rst_i) begin
			meta_nxt = RST_VAL;
			q_nxt = RST_VAL;
		end
	end

	// registers
	always_ff @(posedge clk_i) begin
		meta_r <= meta_nxt;
		q_r <= q_nxt;
	end

	assign q_o = q_r;

endmodule // lhi_sync

`default_nettype wire

// >>> lhi_buf2.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// two-entry buffer: output register plus skid register
// ------------------------------------------------------------
module lhi_buf2 #(
	parameter int unsigned W = 9
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// filling side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// draining side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);

	logic out_v_r, out_v_nxt; // head entry valid
	logic [W-1:0] out_d_r, out_d_nxt; // head entry
	logic skid_v_r, skid_v_nxt; // second entry valid
	logic [W-1:0] skid_d_r, skid_d_nxt; // second entry

	// pop first, then push into the free slot
	always_comb begin
		out_v_nxt = out_v_r;
		out_d_nxt = out_d_r;
		skid_v_nxt = skid_v_r;
		skid_d_nxt = skid_d_r;
		if (out_ready_i && out_v_r) begin
			out_v_nxt = skid_v_r;
			out_d_nxt = skid_d_r;
			skid_v_nxt = 1'b0;
		end
		if (in_valid_i && !skid_v_r) begin
			if (!out_v_nxt) begin
				out_v_nxt = 1'b1;
				out_d_nxt = in_data_i;
			end else begin
				skid_v_nxt = 1'b1;
				skid_d_nxt = in_data_i;
			end
		end
		if (rst_i) begin
			out_v_nxt = 1'b0;
			skid_v_nxt = 1'b0;
			out_d_nxt = '0;
			skid_d_nxt = '0;
		end
	end

	// registers
	always_ff @(posedge clk_i) begin
		out_v_r <= out_v_nxt;
		out_d_r <= out_d_nxt;
		skid_v_r <= skid_v_nxt;
		skid_d_r <= skid_d_nxt;
	end

	assign in_ready_o = !skid_v_r; // full only when both entries hold
	assign out_valid_o = out_v_r;
	assign out_data_o = out_d_r;

endmodule // lhi_buf2

`default_nettype wire

// >>> lhi_host_if.sv
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - parallel strap high: eight-bit bidirectional bus
// - serial: data on bit7, clock bit6
// - chip deselected: all data pins released
// - command/data select classifies every byte
// - host type strap picks 68 or 80
// - 80 style: drive only during read low
// - 80 style: capture at write rising edge
// - 68 style: read pin is enable
// - 68 style: write pin sets direction
// - serial mode: no reads at all
// - internal oscillator unless external clock present
// - status shows busy; busy rejects instructions
module lhi_host_if
	import lhi_pkg::*;
#(
	parameter int unsigned EXT_WIN = LHI_EXT_WIN_CYC
) (
	// system clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// serial link clock (data bit 6 pin)
	input wire logic ser_clk_i,
	// host pins
	input wire logic chip_init_n_i,
	input wire logic cs_n_i,
	input wire logic data_command_select_i,
	input wire logic rd_e_i,
	input wire logic wr_rw_i,
	input wire logic host_type_select_i,
	input wire logic par_ser_select_i,
	input wire logic ext_clock_in_i,
	input wire logic [LHI_DW-1:0] d_i,
	output logic [LHI_DW-1:0] d_o,
	output logic [LHI_DW-1:0] d_oe_n_o,
	// received bytes towards the core
	output logic byte_valid_o,
	output logic [LHI_DW-1:0] byte_o,
	output logic byte_is_data_o,
	input wire logic byte_ready_i,
	// read side of the core
	input wire logic busy_indicator_i,
	input wire logic [LHI_DW-1:0] rd_data_i,
	input wire logic [LHI_DW-2:0] status_i,
	output logic rd_req_o,
	output logic rd_is_data_o,
	output logic rd_done_o,
	// status
	output logic reject_o,
	output logic in_init_o,
	output logic host_is_68_o,
	output logic serial_mode_o,
	output logic ext_clk_sel_o
);

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	if (EXT_WIN < 2 || EXT_WIN > 65535) begin : g_bad_win
		$error("EXT_WIN out of range");
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int unsigned NS = LHI_DW + 8; // bus plus control pins
	logic [NS-1:0] pin_s; // synchronised pins
	logic init_n_s, cs_n_s, dcs_s, rd_s, wr_s, type_s, ps_s, ext_s;
	logic [LHI_DW-1:0] d_s;

	lhi_sync #(.W(NS), .RST_VAL({1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, {LHI_DW{1'b0}}})) u_pin_sync (
		.clk_i(mclk_i),
		.rst_i(rst_i),
		.d_i({chip_init_n_i, cs_n_i, data_command_select_i, rd_e_i, wr_rw_i, host_type_select_i,
			par_ser_select_i, ext_clock_in_i, d_i}),
		.q_o(pin_s)
	);
	assign {init_n_s, cs_n_s, dcs_s, rd_s, wr_s, type_s, ps_s, ext_s, d_s} = pin_s;

	logic init; // reset or init pin low
	assign init = rst_i || !init_n_s;

	// ------------------------------------------------------------
	// straps, caught while in init and frozen after
	// ------------------------------------------------------------
	logic type68_r, type68_nxt; // 68 style selected
	logic par_r, par_nxt; // parallel mode selected
	logic smode_r, smode_nxt; // serial mode flag, kept as its own flop for the output
	logic init_r, init_nxt; // registered init state

	always_comb begin
		type68_nxt = type68_r;
		par_nxt = par_r;
		init_nxt = init;
		if (init) begin
			type68_nxt = (type_s == LHI_TYPE_68);
			par_nxt = (ps_s == LHI_MODE_PAR);
		end
		if (rst_i) begin
			type68_nxt = 1'b0;
			par_nxt = 1'b1;
		end
		smode_nxt = !par_nxt;
	end

	always_ff @(posedge mclk_i) begin
		type68_r <= type68_nxt;
		par_r <= par_nxt;
		smode_r <= smode_nxt;
		init_r <= init_nxt;
	end

	// ------------------------------------------------------------
	// serial link domain
	// ------------------------------------------------------------
	logic ser_init_s; // init seen in the link domain
	logic [LHI_DW-2:0] sh_r, sh_nxt; // shifted bits so far
	logic [2:0] cnt_r, cnt_nxt; // bit index
	logic [LHI_DW:0] sword_r, sword_nxt; // finished byte with select
	logic stog_r, stog_nxt; // toggles once per byte

	lhi_sync #(.W(1), .RST_VAL(1'b1)) u_ser_init (
		.clk_i(ser_clk_i),
		.rst_i(1'b0),
		.d_i(init_r),
		.q_o(ser_init_s)
	);

	// msb first, one bit per rising edge while selected
	always_comb begin
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		sword_nxt = sword_r;
		stog_nxt = stog_r;
		if (cs_n_i) begin
			cnt_nxt = '0;
		end else if (cnt_r == LHI_SER_LAST) begin
			sword_nxt = {data_command_select_i, sh_r, d_i[LHI_SER_IN_BIT]};
			stog_nxt = !stog_r;
			cnt_nxt = '0;
		end else begin
			sh_nxt = {sh_r[LHI_DW-3:0], d_i[LHI_SER_IN_BIT]};
			cnt_nxt = cnt_r + 3'h1;
		end
		if (ser_init_s && cs_n_i) begin // only between frames: a lagging init flag must not eat a frame's first bits
			sh_nxt = '0;
			sword_nxt = '0;
			stog_nxt = 1'b0;
		end
	end

	always_ff @(posedge ser_clk_i) begin
		sh_r <= sh_nxt;
		cnt_r <= cnt_nxt;
		sword_r <= sword_nxt;
		stog_r <= stog_nxt;
	end

	// ------------------------------------------------------------
	// serial byte crossing: toggle in, word held stable
	// ------------------------------------------------------------
	logic stog_s; // synchronised toggle
	logic stog_seen_r, stog_seen_nxt; // last toggle seen
	logic spend_r, spend_nxt; // serial byte waiting for buffer
	logic [LHI_DW:0] sbyte_r, sbyte_nxt; // captured serial byte

	lhi_sync #(.W(1)) u_tog_sync (
		.clk_i(mclk_i),
		.rst_i(rst_i),
		.d_i(stog_r),
		.q_o(stog_s)
	);

	// ------------------------------------------------------------
	// parallel transfer state
	// ------------------------------------------------------------
	lhi_state_t st_r, st_nxt; // transfer state
	logic [LHI_DW:0] pbyte_r, pbyte_nxt; // latched write byte with select
	logic acc_wr, acc_rd; // strobes decoded for the host type
	logic [LHI_DW-1:0] dout_r, dout_nxt; // read data on the bus
	logic oe_n_r, oe_n_nxt; // bus released when high
	logic rdreq_r, rdreq_nxt; // read request pulse
	logic rdis_r, rdis_nxt; // read is display data
	logic rddone_r, rddone_nxt; // display data read finished pulse
	logic rej_r, rej_nxt; // write dropped while busy
	logic in_v; // push into buffer
	logic [LHI_DW:0] in_d; // byte pushed
	logic in_rdy; // buffer has room
	logic [LHI_DW:0] out_d; // buffer head

	// strobe decode
	always_comb begin
		if (type68_r) begin
			acc_wr = rd_s && !wr_s;
			acc_rd = rd_s && wr_s;
		end else begin
			acc_wr = !wr_s;
			acc_rd = !rd_s;
		end
		if (cs_n_s || !par_r || init_r) begin
			acc_wr = 1'b0;
			acc_rd = 1'b0;
		end
	end

	// transfer sequencing and buffer push
	always_comb begin
		st_nxt = st_r;
		pbyte_nxt = pbyte_r;
		dout_nxt = dout_r;
		oe_n_nxt = 1'b1;
		rdreq_nxt = 1'b0;
		rdis_nxt = rdis_r;
		rddone_nxt = 1'b0;
		rej_nxt = 1'b0;
		stog_seen_nxt = stog_s;
		spend_nxt = spend_r;
		sbyte_nxt = sbyte_r;
		in_v = 1'b0;
		in_d = pbyte_r;
		case (st_r)
			LHI_ST_IDLE: begin
				if (acc_wr) begin
					st_nxt = LHI_ST_WR;
				end else if (acc_rd) begin
					st_nxt = LHI_ST_RD;
					rdreq_nxt = 1'b1;
					rdis_nxt = (dcs_s == LHI_DCS_DATA);
				end
			end
			LHI_ST_WR: begin
				pbyte_nxt = {dcs_s, d_s};
				if (!acc_wr) begin
					st_nxt = LHI_ST_PUSH;
				end
			end
			LHI_ST_PUSH: begin
				if (busy_indicator_i) begin
					rej_nxt = 1'b1;
					st_nxt = LHI_ST_IDLE;
				end else if (in_rdy) begin
					in_v = 1'b1;
					st_nxt = LHI_ST_IDLE;
				end
			end
			LHI_ST_RD: begin
				if (acc_rd) begin
					oe_n_nxt = 1'b0;
					if (rdis_r) begin
						dout_nxt = rd_data_i;
					end else begin
						dout_nxt = {busy_indicator_i, status_i};
					end
				end else begin
					rddone_nxt = rdis_r;
					st_nxt = LHI_ST_IDLE;
				end
			end
			default: begin
				st_nxt = LHI_ST_IDLE;
			end
		endcase
		// serial byte arrives: hold until the buffer takes it or busy drops it
		if (stog_s != stog_seen_r && !par_r) begin
			spend_nxt = 1'b1;
			sbyte_nxt = sword_r;
		end else if (spend_r) begin
			in_d = sbyte_r;
			if (busy_indicator_i) begin
				rej_nxt = 1'b1;
				spend_nxt = 1'b0;
			end else if (in_rdy) begin
				in_v = 1'b1;
				spend_nxt = 1'b0;
			end
		end
		if (init) begin
			st_nxt = LHI_ST_IDLE;
			pbyte_nxt = '0;
			dout_nxt = '0;
			oe_n_nxt = 1'b1;
			rdreq_nxt = 1'b0;
			rdis_nxt = 1'b0;
			rddone_nxt = 1'b0;
			rej_nxt = 1'b0;
			spend_nxt = 1'b0;
			sbyte_nxt = '0;
			in_v = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		st_r <= st_nxt;
		pbyte_r <= pbyte_nxt;
		dout_r <= dout_nxt;
		oe_n_r <= oe_n_nxt;
		rdreq_r <= rdreq_nxt;
		rdis_r <= rdis_nxt;
		rddone_r <= rddone_nxt;
		rej_r <= rej_nxt;
		stog_seen_r <= stog_seen_nxt;
		spend_r <= spend_nxt;
		sbyte_r <= sbyte_nxt;
	end

	// ------------------------------------------------------------
	// byte buffer towards the core
	// ------------------------------------------------------------
	lhi_buf2 #(.W(LHI_DW + 1)) u_buf (
		.clk_i(mclk_i),
		.rst_i(init),
		.in_valid_i(in_v),
		.in_data_i(in_d),
		.in_ready_o(in_rdy),
		.out_valid_o(byte_valid_o),
		.out_data_o(out_d),
		.out_ready_i(byte_ready_i)
	);

	// ------------------------------------------------------------
	// external clock activity: select it while edges keep coming
	// ------------------------------------------------------------
	logic ext_d_r, ext_d_nxt; // previous synchronised level
	logic [15:0] ext_cnt_r, ext_cnt_nxt; // cycles left in window
	logic ext_sel_r, ext_sel_nxt; // external clock in use

	always_comb begin
		ext_d_nxt = ext_s;
		ext_cnt_nxt = ext_cnt_r;
		if (ext_s != ext_d_r) begin
			ext_cnt_nxt = 16'(EXT_WIN);
		end else if (ext_cnt_r != '0) begin
			ext_cnt_nxt = ext_cnt_r - 16'h1;
		end
		ext_sel_nxt = (ext_cnt_nxt != '0);
		if (rst_i) begin
			ext_d_nxt = 1'b0;
			ext_cnt_nxt = '0;
			ext_sel_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		ext_d_r <= ext_d_nxt;
		ext_cnt_r <= ext_cnt_nxt;
		ext_sel_r <= ext_sel_nxt;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign byte_o = out_d[LHI_DW-1:0];
	assign byte_is_data_o = out_d[LHI_DW];
	assign d_o = dout_r;
	assign d_oe_n_o = {LHI_DW{oe_n_r}};
	assign rd_req_o = rdreq_r;
	assign rd_is_data_o = rdis_r;
	assign rd_done_o = rddone_r;
	assign reject_o = rej_r;
	assign in_init_o = init_r;
	assign host_is_68_o = type68_r;
	assign serial_mode_o = smode_r;
	assign ext_clk_sel_o = ext_sel_r;

endmodule // lhi_host_if

`default_nettype wire

// >>> lhi_host_if_assertions.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// port checker for the host interface
// ------------------------------------------------------------
module lhi_host_if_assertions
	import lhi_pkg::*;
(
	// clock, reset and host pins
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic chip_init_n_i,
	input wire logic cs_n_i,
	input wire logic rd_e_i,
	// core side inputs
	input wire logic busy_indicator_i,
	input wire logic byte_ready_i,
	input wire logic [LHI_DW-1:0] rd_data_i,
	input wire logic [LHI_DW-2:0] status_i,
	// outputs under watch
	input wire logic [LHI_DW-1:0] d_o,
	input wire logic [LHI_DW-1:0] d_oe_n_o,
	input wire logic byte_valid_o,
	input wire logic [LHI_DW-1:0] byte_o,
	input wire logic byte_is_data_o,
	input wire logic rd_req_o,
	input wire logic rd_is_data_o,
	input wire logic rd_done_o,
	input wire logic reject_o,
	input wire logic in_init_o,
	input wire logic host_is_68_o,
	input wire logic serial_mode_o
);
	// one domain: clock and reset given once
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_ser_quiet;
		serial_mode_o |-> (&d_oe_n_o) && !rd_req_o;
	endproperty
	a_ser_quiet: assert property (p_ser_quiet) else $error("serial mode drove bus or read");
	property p_cs_release;
		cs_n_i [*5] |-> &d_oe_n_o;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("bus driven while deselected");
	property p_oe_uniform;
		d_oe_n_o == '0 || d_oe_n_o == '1;
	endproperty
	a_oe_uniform: assert property (p_oe_uniform) else $error("enables of bus bits differ");
	property p_rd80_low;
		(!host_is_68_o && rd_e_i) [*5] |-> &d_oe_n_o;
	endproperty
	a_rd80_low: assert property (p_rd80_low) else $error("bus driven with read strobe high");
	property p_drive_after_req;
		rd_req_o |=> !d_oe_n_o[0];
	endproperty
	a_drive_after_req: assert property (p_drive_after_req) else $error("no drive after read start");
	property p_read_value;
		!d_oe_n_o[0] |-> d_o == (rd_is_data_o ? $past(rd_data_i) : $past({busy_indicator_i, status_i}));
	endproperty
	a_read_value: assert property (p_read_value) else $error("read byte wrong");
	property p_reject_busy;
		reject_o |-> $past(busy_indicator_i) || $past(busy_indicator_i, 2);
	endproperty
	a_reject_busy: assert property (p_reject_busy) else $error("write dropped while not busy");
	property p_init_hold;
		!chip_init_n_i [*5] |-> in_init_o && !byte_valid_o && (&d_oe_n_o);
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("init pin low but interface active");
	property p_byte_stands;
		byte_valid_o && !byte_ready_i && chip_init_n_i |=> byte_valid_o && $stable({byte_is_data_o, byte_o});
	endproperty
	a_byte_stands: assert property (p_byte_stands) else $error("pending byte changed");

	// main scenarios reached
	c_reject: cover property (reject_o);
	c_done: cover property (rd_done_o);
	c_ser_byte: cover property (byte_valid_o && serial_mode_o);
endmodule // lhi_host_if_assertions

bind lhi_host_if lhi_host_if_assertions i_lhi_host_if_assertions (
	.mclk_i(mclk_i), .rst_i(rst_i), .chip_init_n_i(chip_init_n_i), .cs_n_i(cs_n_i), .rd_e_i(rd_e_i),
	.busy_indicator_i(busy_indicator_i), .byte_ready_i(byte_ready_i), .rd_data_i(rd_data_i),
	.status_i(status_i), .d_o(d_o), .d_oe_n_o(d_oe_n_o), .byte_valid_o(byte_valid_o), .byte_o(byte_o),
	.byte_is_data_o(byte_is_data_o), .rd_req_o(rd_req_o), .rd_is_data_o(rd_is_data_o),
	.rd_done_o(rd_done_o), .reject_o(reject_o), .in_init_o(in_init_o), .host_is_68_o(host_is_68_o),
	.serial_mode_o(serial_mode_o));
`default_nettype wire

// >>> lhi_mpu_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// host processor model: 68/80 parallel and serial writer
// ------------------------------------------------------------
module lhi_mpu_model
	import lhi_pkg::*;
(
	// clock and resolved bus
	input wire logic mclk_i,
	input wire logic [LHI_DW-1:0] bus_i,
	// host pins
	output logic cs_n_o,
	output logic dcs_o,
	output logic rd_e_o,
	output logic wr_rw_o,
	output logic sclk_o,
	output logic [LHI_DW-1:0] hd_o
);
	// deselect; released bus shows a changed pattern
	task automatic idle(input logic t68);
		cs_n_o = 1'b1;
		rd_e_o = ~t68;
		wr_rw_o = 1'b1;
		hd_o = ~hd_o;
	endtask

	// link clock pulses while deselected, so the link side takes in the init
	task automatic sclk_burst(input int n);
		repeat (n) begin
			#62 sclk_o = 1'b1;
			#63 sclk_o = 1'b0;
		end
	endtask

	// one parallel transfer, strobe active for six cycles
	task automatic xfer(input logic t68, input logic rd, input logic dcs, input logic [7:0] wd,
		output logic [7:0] rdv);
		@(negedge mclk_i);
		cs_n_o = 1'b0;
		dcs_o = dcs;
		hd_o = wd;
		wr_rw_o = t68 ? rd : 1'b1;
		@(negedge mclk_i);
		if (t68) begin
			rd_e_o = 1'b1;
		end else if (rd) begin
			rd_e_o = 1'b0;
		end else begin
			wr_rw_o = 1'b0;
		end
		repeat (6) @(negedge mclk_i);
		rdv = bus_i;
		rd_e_o = ~t68;
		wr_rw_o = t68 ? rd : 1'b1;
		// data held past the strobe end
		repeat (4) @(negedge mclk_i);
		idle(t68);
		repeat (4) @(negedge mclk_i);
	endtask

	// serial byte, msb first; strobes left untouched
	task automatic ser(input logic dcs, input logic [7:0] b);
		cs_n_o = 1'b0;
		dcs_o = dcs;
		for (int i = 7; i >= 0; i--) begin
			hd_o[LHI_SER_IN_BIT] = b[i];
			#62;
			sclk_o = 1'b1;
			#63;
			sclk_o = 1'b0;
		end
		#125;
		cs_n_o = 1'b1;
	endtask

	// time-zero pin levels
	initial begin
		sclk_o = 1'b0;
		dcs_o = 1'b0;
		hd_o = 8'h00;
		idle(1'b0);
	end
endmodule // lhi_mpu_model
`default_nettype wire

// >>> lhi_host_if_tb.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// self-checking bench for the host interface
// ------------------------------------------------------------
module lhi_host_if_tb;
	import lhi_pkg::*;
	// driven by the bench
	logic mclk = 1'b0, rst = 1'b1, init_n = 1'b1, htype = 1'b0, pmode = 1'b1, ext = 1'b0;
	logic ready = 1'b0, busy = 1'b0;
	logic [7:0] rdat = 8'h3c;
	logic [6:0] stat = 7'h2a;
	// host pins and design outputs
	wire logic cs_n, dcs, rde, wrw, sclk;
	wire logic [7:0] hd, bus;
	logic [7:0] d_o, oe_n, rx, r;
	logic valid, is_data, rd_req, rd_is_data, rd_done, reject, in_init, is68, smode, extsel;
	int num_errors = 0, n_tests = 0, rej_cnt = 0, req_cnt = 0, done_cnt = 0;

	// bus level: device where enabled, host otherwise
	assign bus = (~oe_n & d_o) | (oe_n & hd);
	always #50 mclk = ~mclk;
	always @(posedge mclk) if (reject === 1'b1) rej_cnt++;
	always @(posedge mclk) if (rd_req === 1'b1) req_cnt++;
	always @(posedge mclk) if (rd_done === 1'b1) done_cnt++;

	lhi_host_if i_lhi_host_if (.mclk_i(mclk), .rst_i(rst), .ser_clk_i(sclk), .chip_init_n_i(init_n),
		.cs_n_i(cs_n), .data_command_select_i(dcs), .rd_e_i(rde), .wr_rw_i(wrw), .host_type_select_i(htype),
		.par_ser_select_i(pmode), .ext_clock_in_i(ext), .d_i(bus), .d_o(d_o), .d_oe_n_o(oe_n),
		.byte_valid_o(valid), .byte_o(rx), .byte_is_data_o(is_data), .byte_ready_i(ready),
		.busy_indicator_i(busy), .rd_data_i(rdat), .status_i(stat), .rd_req_o(rd_req),
		.rd_is_data_o(rd_is_data), .rd_done_o(rd_done), .reject_o(reject), .in_init_o(in_init),
		.host_is_68_o(is68), .serial_mode_o(smode), .ext_clk_sel_o(extsel));
	lhi_mpu_model i_lhi_mpu_model (.mclk_i(mclk), .bus_i(bus), .cs_n_o(cs_n), .dcs_o(dcs), .rd_e_o(rde),
		.wr_rw_o(wrw), .sclk_o(sclk), .hd_o(hd));

	// compare and count
	task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask

	// verdict and end of run
	task automatic tally_and_finish();
		if (num_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// wait for a byte, compare it, pop it
	task automatic get_byte(input logic dc, input logic [7:0] b);
		int n;
		n = 0;
		while (valid !== 1'b1 && n < 80) begin
			@(negedge mclk);
			n++;
		end
		chk("rx byte", {is_data, rx}, {dc, b});
		ready = 1'b1;
		@(negedge mclk);
		ready = 1'b0;
		@(negedge mclk);
	endtask

	// new straps caught while the init pin is low
	task automatic reinit(input logic ty, input logic ps, input logic [8:0] exp);
		int n;
		n = 0;
		htype = ty;
		pmode = ps;
		i_lhi_mpu_model.idle(ty);
		init_n = 1'b0;
		repeat (4) @(negedge mclk);
		i_lhi_mpu_model.sclk_burst(4);
		repeat (4) @(negedge mclk);
		chk("init hold", {in_init, oe_n}, 9'h1ff);
		init_n = 1'b1;
		while (in_init !== 1'b0 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		repeat (4) @(negedge mclk);
		chk("straps", {in_init, 6'h0, is68, smode}, exp);
	endtask

	// 80 style writes into a stalled buffer, then drained in order
	task automatic s_wr80_fill();
		i_lhi_mpu_model.xfer(1'b0, 1'b0, 1'b1, 8'ha5, r);
		i_lhi_mpu_model.xfer(1'b0, 1'b0, 1'b0, 8'h5a, r);
		i_lhi_mpu_model.xfer(1'b0, 1'b0, 1'b1, 8'hc3, r);
		chk("stall valid", {8'h0, valid}, 9'h001);
		get_byte(1'b1, 8'ha5);
		get_byte(1'b0, 8'h5a);
		get_byte(1'b1, 8'hc3);
	endtask

	// busy drops a write and a status read still answers; data read after busy clears
	task automatic s_busy_read80();
		busy = 1'b1;
		i_lhi_mpu_model.xfer(1'b0, 1'b0, 1'b1, 8'h11, r);
		chk("reject", {valid, rej_cnt[7:0]}, 9'h001);
		i_lhi_mpu_model.xfer(1'b0, 1'b1, 1'b0, 8'h00, r);
		chk("status", {1'b0, r}, 9'h0aa);
		busy = 1'b0;
		i_lhi_mpu_model.xfer(1'b0, 1'b1, 1'b1, 8'h00, r);
		chk("rd data", {1'b0, r}, 9'h03c);
		chk("rd pulses", {rd_is_data, req_cnt[3:0], done_cnt[3:0]}, 9'h121);
		chk("released", {1'b0, oe_n}, 9'h0ff);
	endtask

	// 68 style write and data read
	task automatic s_host68();
		reinit(1'b1, 1'b1, 9'h002);
		i_lhi_mpu_model.xfer(1'b1, 1'b0, 1'b1, 8'h96, r);
		get_byte(1'b1, 8'h96);
		i_lhi_mpu_model.xfer(1'b1, 1'b1, 1'b1, 8'h00, r);
		chk("rd68", {1'b0, r}, 9'h03c);
	endtask

	// serial bytes of both kinds; bus never driven
	task automatic s_serial();
		reinit(1'b0, 1'b0, 9'h001);
		i_lhi_mpu_model.ser(1'b1, 8'hb2);
		get_byte(1'b1, 8'hb2);
		i_lhi_mpu_model.ser(1'b0, 8'h4d);
		get_byte(1'b0, 8'h4d);
		chk("ser bus", {1'b0, oe_n}, 9'h0ff);
	endtask

	// external clock seen, then lost
	task automatic s_ext();
		repeat (10) begin
			#300 ext = ~ext;
		end
		chk("ext on", {8'h0, extsel}, 9'h001);
		repeat (40) @(negedge mclk);
		chk("ext off", {8'h0, extsel}, 9'h000);
	endtask

	// main sequence
	initial begin
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		reinit(1'b0, 1'b1, 9'h000);
		s_wr80_fill();
		s_busy_read80();
		s_host68();
		s_serial();
		s_ext();
		tally_and_finish();
	end

	// hang guard: far beyond the expected run
	initial begin
		#2000000;
		num_errors++;
		tally_and_finish();
	end
endmodule // lhi_host_if_tb
`default_nettype wire
